// [rtl/lbrws_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - precharge overlaps the last read data
// - back-to-back reads concatenate or interrupt
// - read every clock cuts running burst
// - burst terminate stops read, row stays open
// - precharge two clocks after read gives two pairs
// - read auto precharge starts BL/2 clocks later
// - write takes bank, column, auto precharge choice
// - mask low stores byte, high keeps it
// - first rising strobe edge, then every edge
// - idle data pins high impedance, data ignored
// - new write appends or truncates previous
// - next burst data follows without a gap
// - read cutting a write stores earlier pairs
// - x16 lower strobe low byte, upper high; here one strobe times all four lanes
// - strobe n times byte lane n; here dqs_clk_i times every lane
// - first read data after CAS latency
// - burst terminate acts after CAS latency
// - A10 auto precharge per command only
module lbrws_top
    import lbrws_pkg::*;
(
    // system clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // write strobe clock from the controller
    input wire logic dqs_clk_i,
    // command and address, synchronous to clk_i
    input wire logic [2:0] cmd_i,
    input wire logic [BANK_W-1:0] ba_i,
    input wire logic [COL_W-1:0] col_i,
    input wire logic a10_i,
    // configuration levels
    input wire logic [1:0] bl_sel_i,
    input wire logic cl3_i,
    // write data and masks, timed by dqs_clk_i
    input wire logic [DQ_W-1:0] dq_i,
    input wire logic [LANES-1:0] dm_i,
    // read data pair and pin enables
    output logic [PAIR_W-1:0] rd_pair_o,
    output logic rd_valid_o,
    output logic dq_oe_n_o,
    output logic dqs_oe_n_o,
    // precharge and bank status
    output logic pre_start_o,
    output logic [BANK_W-1:0] pre_bank_o,
    output logic [NBANK-1:0] bank_open_o,
    output logic rd_active_o,
    output logic wr_active_o
);
    // ****************************************
    // helper functions
    // ****************************************

    // pairs in one burst for the selected burst length
    function automatic logic [CNT_W-1:0] pairs_of(input logic [1:0] sel);
        logic [CNT_W-1:0] n;
        n = CNT_ONE << sel;
        return n;
    endfunction

    // next pair column, wrapping inside the burst
    function automatic logic [PCOL_W-1:0] next_col(input logic [PCOL_W-1:0] c,
                                                   input logic [1:0] sel);
        logic [PCOL_W-1:0] m;
        logic [PCOL_W-1:0] inc;
        m = PCOL_W'(pairs_of(sel)) - PCOL_W'(1);
        inc = c + PCOL_W'(1);
        return (c & ~m) | (inc & m);
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    // decoded command strobes
    logic is_read;
    logic is_write;
    logic is_bst;
    logic is_pre;
    logic is_act;
    logic [CNT_W-1:0] burst_pairs;
    logic [PCOL_W-1:0] cmd_pcol;
    // read fetch side
    logic [CNT_W-1:0] rd_left_q;
    logic [BANK_W-1:0] rd_bank_q;
    logic [PCOL_W-1:0] rd_pcol_q;
    logic fetch;
    logic rd_stop; // command that ends read fetching this cycle
    logic [MEM_AW-1:0] rd_addr;
    logic [PAIR_W-1:0] mem_rdata;
    // latency pipeline
    logic vld1_q;
    logic vld2_q;
    logic [PAIR_W-1:0] d2_q;
    logic [PAIR_W-1:0] rd_pair_q;
    logic rd_valid_q;
    logic pre_stage;
    // read auto precharge countdown
    logic [CNT_W-1:0] ap_cnt_q;
    logic [BANK_W-1:0] ap_bank_q;
    // write side
    logic [CNT_W-1:0] wr_left_q;
    logic [BANK_W-1:0] wr_bank_q;
    logic [PCOL_W-1:0] wr_pcol_q;
    logic wr_ap_q;
    logic wr_store;
    logic wr_last;
    // strobe-domain pair and its toggle crossing
    logic [PAIR_W-1:0] cap_pair;
    logic [PMASK_W-1:0] cap_mask;
    logic cap_tgl;
    logic tgl_s1_q;
    logic tgl_s2_q;
    logic tgl_s3_q;
    logic pair_evt;
    // precharge event and bank state
    logic pre_q;
    logic [BANK_W-1:0] pre_bank_q;
    logic [NBANK-1:0] open_q;

    // ****************************************
    // command decode
    // ****************************************

    // commands are sampled on the system clock edge
    always_comb begin
        is_read = (cmd_i == CMD_READ);
        is_write = (cmd_i == CMD_WRITE);
        is_bst = (cmd_i == CMD_BST);
        is_pre = (cmd_i == CMD_PRE);
        is_act = (cmd_i == CMD_ACT);
        burst_pairs = pairs_of(bl_sel_i);
        cmd_pcol = col_i[PCOL_LSB +: PCOL_W];
    end

    // ****************************************
    // read fetch
    // ****************************************

    // a new read fetches its first pair in the command cycle
    // a stopping command takes effect in its own cycle: x clocks give x pairs
    assign rd_stop = is_bst | is_write | (is_pre && (ba_i == rd_bank_q || a10_i));
    assign fetch = is_read | ((rd_left_q != CNT_ZERO) & ~rd_stop);
    assign rd_addr = is_read ? {ba_i, cmd_pcol} : {rd_bank_q, rd_pcol_q};

    // remaining pairs of the running read burst
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_left_q <= CNT_ZERO;
            rd_bank_q <= '0;
            rd_pcol_q <= '0;
        end else if (is_read) begin
            // newest read wins: concatenates at BL2, cuts longer bursts
            rd_left_q <= burst_pairs - CNT_ONE;
            rd_bank_q <= ba_i;
            rd_pcol_q <= next_col(cmd_pcol, bl_sel_i);
        end else if (is_bst || is_write) begin
            // terminate keeps the row open; only fetching stops
            rd_left_q <= CNT_ZERO;
        end else if (is_pre && (ba_i == rd_bank_q || a10_i)) begin
            // pairs fetched before the precharge still go out
            rd_left_q <= CNT_ZERO;
        end else if (rd_left_q != CNT_ZERO) begin
            // count pairs against the burst length
            rd_left_q <= rd_left_q - CNT_ONE;
            rd_pcol_q <= next_col(rd_pcol_q, bl_sel_i);
        end
    end

    // array instance; write port from the strobe path
    lbrws_mem u_mem (
        .clk_i(clk_i),
        .wr_en_i(wr_store),
        .wr_addr_i({wr_bank_q, wr_pcol_q}),
        .wr_data_i(cap_pair),
        .wr_be_i(~cap_mask),
        .rd_addr_i(rd_addr),
        .rd_data_o(mem_rdata)
    );

    // ****************************************
    // CAS latency pipeline
    // ****************************************

    // array output lands one clock after fetch, one more stage for CL3
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vld1_q <= 1'b0;
            vld2_q <= 1'b0;
        end else begin
            vld1_q <= fetch;
            vld2_q <= vld1_q;
        end
    end

    // extra data stage used only at CL3
    always_ff @(posedge clk_i) begin
        d2_q <= mem_rdata;
    end

    // data appears CL clocks after the read; terminate shares that delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_valid_q <= 1'b0;
            rd_pair_q <= '0;
        end else if (cl3_i) begin
            rd_valid_q <= vld2_q;
            rd_pair_q <= d2_q;
        end else begin
            rd_valid_q <= vld1_q;
            rd_pair_q <= mem_rdata;
        end
    end

    // strobe enable opens one clock early for the read preamble
    assign pre_stage = cl3_i ? vld2_q : vld1_q;
    assign rd_pair_o = rd_pair_q;
    assign rd_valid_o = rd_valid_q;
    // pins float whenever no read data is due
    assign dq_oe_n_o = ~rd_valid_q;
    assign dqs_oe_n_o = ~(rd_valid_q | pre_stage);

    // ****************************************
    // read auto precharge
    // ****************************************

    // countdown from the read; A10 is looked at only with that command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ap_cnt_q <= CNT_ZERO;
            ap_bank_q <= '0;
        end else if (is_read && a10_i) begin
            ap_cnt_q <= burst_pairs;
            ap_bank_q <= ba_i;
        end else if (is_read) begin
            // a plain read drops any earlier pending choice
            ap_cnt_q <= CNT_ZERO;
        end else if (ap_cnt_q != CNT_ZERO) begin
            ap_cnt_q <= ap_cnt_q - CNT_ONE;
        end
    end

    // ****************************************
    // write strobe crossing
    // ****************************************

    // capture runs on the strobe clock
    lbrws_capture u_cap (
        .dqs_clk_i(dqs_clk_i),
        .rst_i(rst_i),
        .dq_i(dq_i),
        .dm_i(dm_i),
        .pair_o(cap_pair),
        .mask_o(cap_mask),
        .pair_tgl_o(cap_tgl)
    );

    // toggle synchroniser; pair data is stable while the toggle settles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
        end else begin
            tgl_s1_q <= cap_tgl;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
        end
    end

    // one pulse per completed strobe pair
    assign pair_evt = tgl_s2_q ^ tgl_s3_q;
    // pairs outside a write burst are dropped
    assign wr_store = pair_evt && (wr_left_q != CNT_ZERO);
    assign wr_last = wr_store && (wr_left_q == CNT_ONE);

    // ****************************************
    // write burst
    // ****************************************

    // write burst state: bank, column and auto precharge per command
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_left_q <= CNT_ZERO;
            wr_bank_q <= '0;
            wr_pcol_q <= '0;
            wr_ap_q <= 1'b0;
        end else if (is_write) begin
            // new write appends or truncates; next pair is its first
            wr_left_q <= burst_pairs;
            wr_bank_q <= ba_i;
            wr_pcol_q <= cmd_pcol;
            wr_ap_q <= a10_i;
        end else if (is_read || (is_pre && (ba_i == wr_bank_q || a10_i))) begin
            // only pairs stored so far remain in the array
            wr_left_q <= CNT_ZERO;
            wr_ap_q <= 1'b0;
        end else if (wr_store) begin
            // burst ends after its programmed pair count
            wr_left_q <= wr_left_q - CNT_ONE;
            wr_pcol_q <= next_col(wr_pcol_q, bl_sel_i);
        end
    end

    // ****************************************
    // precharge start and bank state
    // ****************************************

    // precharge begins while the last read pairs still drive out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 1'b0;
            pre_bank_q <= '0;
        end else if (is_pre) begin
            pre_q <= 1'b1;
            pre_bank_q <= ba_i;
        end else if (wr_last && wr_ap_q) begin
            // write auto precharge after the final pair
            pre_q <= 1'b1;
            pre_bank_q <= wr_bank_q;
        end else if (is_read && a10_i && burst_pairs == CNT_ONE) begin
            // BL2: BL/2 is a single clock
            pre_q <= 1'b1;
            pre_bank_q <= ba_i;
        end else if (ap_cnt_q == CNT_TWO) begin
            // read auto precharge lands BL/2 clocks after the read
            pre_q <= 1'b1;
            pre_bank_q <= ap_bank_q;
        end else begin
            pre_q <= 1'b0;
        end
    end

    // open rows per bank; terminate leaves them open
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_q <= '0;
        end else if (is_act) begin
            open_q[ba_i] <= 1'b1;
        end else if (is_pre && a10_i) begin
            open_q <= '0;
        end else if (is_pre) begin
            open_q[ba_i] <= 1'b0;
        end else if (pre_q) begin
            open_q[pre_bank_q] <= 1'b0;
        end
    end

    // status outputs
    assign pre_start_o = pre_q;
    assign pre_bank_o = pre_bank_q;
    assign bank_open_o = open_q;
    assign rd_active_o = rd_valid_q | (rd_left_q != CNT_ZERO);
    assign wr_active_o = (wr_left_q != CNT_ZERO);
endmodule // lbrws_top
`default_nettype wire

// [rtl/lbrws_pkg.sv]
// ****************************************
// shared constants of the burst sequencer
// ****************************************
package lbrws_pkg;
    // data organisation: four byte lanes, two elements per pair
    localparam int unsigned LANES = 4;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned DQ_W = LANES * BYTE_W;
    localparam int unsigned PAIR_W = 2 * DQ_W;
    localparam int unsigned PMASK_W = 2 * LANES;
    // addressing: bank plus pair column inside the small array
    localparam int unsigned BANK_W = 2;
    localparam int unsigned NBANK = 4;
    localparam int unsigned COL_W = 10;
    localparam int unsigned PCOL_W = 6;
    localparam int unsigned MEM_AW = BANK_W + PCOL_W;
    // pair counter, enough for burst length 16
    localparam int unsigned CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_TWO = 4'h2;
    // command codes on the command pins
    localparam logic [2:0] CMD_NOP = 3'h0;
    localparam logic [2:0] CMD_ACT = 3'h1;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_WRITE = 3'h3;
    localparam logic [2:0] CMD_BST = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h5;
    // burst length select: 0 -> 2, 1 -> 4, 2 -> 8, 3 -> 16
    localparam logic [1:0] BL_SEL_2 = 2'h0;
    localparam logic [1:0] BL_SEL_4 = 2'h1;
    localparam logic [1:0] BL_SEL_8 = 2'h2;
    // pair column bits taken from the column address
    localparam int unsigned PCOL_LSB = 1;
endpackage : lbrws_pkg

// [rtl/lbrws_mem.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// pair-wide array with byte write enables
// ****************************************
module lbrws_mem
    import lbrws_pkg::*;
(
    // clock
    input wire logic clk_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [MEM_AW-1:0] wr_addr_i,
    input wire logic [PAIR_W-1:0] wr_data_i,
    input wire logic [PMASK_W-1:0] wr_be_i,
    // read port, data registered
    input wire logic [MEM_AW-1:0] rd_addr_i,
    output logic [PAIR_W-1:0] rd_data_o
);
    // storage, no reset: contents are undefined at power up
    logic [PAIR_W-1:0] mem_q [0:(1<<MEM_AW)-1];

    // one byte per lane and element; lane n owns bits 8n+7..8n and 8n+39..8n+32
    // a single process keeps the array to one writer
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < PMASK_W; b++) begin
            // masked bytes keep the old array contents
            if (wr_en_i && wr_be_i[b]) begin
                mem_q[wr_addr_i][b*BYTE_W +: BYTE_W] <= wr_data_i[b*BYTE_W +: BYTE_W];
            end
        end
    end

    // registered read
    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule // lbrws_mem
`default_nettype wire

// [rtl/lbrws_capture.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// strobe-domain write data capture
// ****************************************
module lbrws_capture
    import lbrws_pkg::*;
(
    // strobe clock and system reset
    input wire logic dqs_clk_i,
    input wire logic rst_i,
    // data pins sampled on strobe edges
    input wire logic [DQ_W-1:0] dq_i,
    input wire logic [LANES-1:0] dm_i,
    // captured pair, held until the next pair completes
    output logic [PAIR_W-1:0] pair_o,
    output logic [PMASK_W-1:0] mask_o,
    output logic pair_tgl_o
);
    // reset carried into the strobe domain
    logic rst_s1_q;
    logic rst_s2_q;
    // first element of a pair, caught on the rising edge
    logic [DQ_W-1:0] first_q;
    logic [LANES-1:0] first_m_q;

    // reset synchroniser
    always_ff @(posedge dqs_clk_i) begin
        rst_s1_q <= rst_i;
        rst_s2_q <= rst_s1_q;
    end

    // rising edge takes the even element with its masks
    always_ff @(posedge dqs_clk_i) begin
        first_q <= dq_i;
        first_m_q <= dm_i;
    end

    // falling edge completes the pair and flips the toggle
    always_ff @(negedge dqs_clk_i) begin
        if (rst_s2_q) begin
            pair_tgl_o <= 1'b0;
            pair_o <= '0;
            mask_o <= '1;
        end else begin
            pair_o <= {dq_i, first_q};
            mask_o <= {dm_i, first_m_q};
            pair_tgl_o <= ~pair_tgl_o;
        end
    end
endmodule // lbrws_capture
`default_nettype wire

// [verification/lbrws_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks of the burst sequencer
// ****
module lbrws_top_props
    import lbrws_pkg::*;
(
    // clock, reset, command
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] cmd_i,
    input wire logic [BANK_W-1:0] ba_i,
    input wire logic a10_i,
    input wire logic [1:0] bl_sel_i,
    input wire logic cl3_i,
    // watched outputs
    input wire logic rd_valid_o,
    input wire logic dq_oe_n_o,
    input wire logic dqs_oe_n_o,
    input wire logic pre_start_o,
    input wire logic [BANK_W-1:0] pre_bank_o,
    input wire logic [NBANK-1:0] bank_open_o,
    input wire logic wr_active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // reset keeps pins released, checked through the release edge
    rst_quiet_a: assert property (disable iff (1'b0) rst_i |=>
        !rd_valid_o && dq_oe_n_o && dqs_oe_n_o && !pre_start_o) else $error("outputs active in reset");
    dq_turn_a: assert property (dq_oe_n_o == !rd_valid_o)
        else $error("data pins driven without read data");
    rd_lat_a: assert property (cmd_i == CMD_READ |-> if (cl3_i) (##3 rd_valid_o) else (##2 rd_valid_o))
        else $error("read data late or early");
    rd_pre_a: assert property ($rose(rd_valid_o) |-> !$past(dqs_oe_n_o))
        else $error("no strobe preamble before read data");
    rd_len_a: assert property ((cmd_i == CMD_READ && bl_sel_i == BL_SEL_4 && !cl3_i ##1
        cmd_i == CMD_NOP [*3]) |-> rd_valid_o ##1 !rd_valid_o) else $error("read burst length wrong");
    bst_stop_a: assert property ((cmd_i == CMD_READ && !cl3_i ##1 cmd_i == CMD_BST ##1
        cmd_i == CMD_NOP) |-> rd_valid_o ##1 !rd_valid_o) else $error("terminate did not stop read");
    bst_open_a: assert property (cmd_i == CMD_BST |=> bank_open_o == $past(bank_open_o))
        else $error("terminate closed a row");
    pre_cut_a: assert property ((cmd_i == CMD_READ && !cl3_i && bl_sel_i == BL_SEL_8 ##1
        cmd_i == CMD_NOP ##1 cmd_i == CMD_PRE) |-> rd_valid_o [*2] ##1 !rd_valid_o)
        else $error("precharge cut gave wrong pair count");
    ap_read_a: assert property ((cmd_i == CMD_READ && a10_i && bl_sel_i == BL_SEL_8 ##1
        cmd_i == CMD_NOP [*3]) |=> pre_start_o && pre_bank_o == $past(ba_i, 4))
        else $error("auto precharge not at half burst");
    pre_cmd_a: assert property (cmd_i == CMD_PRE && !a10_i && bank_open_o[ba_i] |=>
        pre_start_o && pre_bank_o == $past(ba_i)) else $error("precharge did not start");
    wr_arm_a: assert property (cmd_i == CMD_WRITE |=> wr_active_o)
        else $error("write not armed");
    // main scenarios reached
    bst_c: cover property (cmd_i == CMD_BST);
    ap_c: cover property (pre_start_o && !$past(cmd_i == CMD_PRE));
    wr_c: cover property (wr_active_o ##1 !wr_active_o);
endmodule // lbrws_top_props

bind lbrws_top lbrws_top_props i_lbrws_top_props (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd_i), .ba_i(ba_i), .a10_i(a10_i),
    .bl_sel_i(bl_sel_i), .cl3_i(cl3_i), .rd_valid_o(rd_valid_o), .dq_oe_n_o(dq_oe_n_o),
    .dqs_oe_n_o(dqs_oe_n_o), .pre_start_o(pre_start_o), .pre_bank_o(pre_bank_o),
    .bank_open_o(bank_open_o), .wr_active_o(wr_active_o)
);
`default_nettype wire

// [verification/lbrws_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// controller write side: strobe and data
// ****
module lbrws_ctrl_model
    import lbrws_pkg::*;
(
    // reset, strobe must run while it is high
    input wire logic rst_i,
    // write pins towards the device
    output logic dqs_clk_o,
    output logic [DQ_W-1:0] dq_o,
    output logic [LANES-1:0] dm_o
);
    logic busy = 1'b0; // a pair is on the wire
    int tail = 0; // strobe edges after reset that flush the capture reset
    initial begin
        dqs_clk_o = 1'b0;
        dq_o = '0;
        dm_o = '0;
    end
    // free-running in reset and for six edges after it, else low between frames
    always begin
        #6;
        if (rst_i) begin
            dqs_clk_o = ~dqs_clk_o;
            tail = 6;
        end else if (tail > 0) begin
            // a few edges carry the reset release into the strobe domain
            dqs_clk_o = ~dqs_clk_o;
            tail--;
        end else if (!busy) begin
            dqs_clk_o = 1'b0; // preamble and postamble low
        end
    end
    // one pair: low element on rise, high on fall
    task automatic send_pair(input logic [PAIR_W-1:0] d, input logic [PMASK_W-1:0] m);
        busy = 1'b1;
        dq_o = d[31:0]; // lane n on bits 8n+7..8n
        dm_o = m[3:0];
        #3 dqs_clk_o = 1'b1;
        #3 dq_o = d[63:32];
        dm_o = m[7:4];
        #3 dqs_clk_o = 1'b0;
        #3 dq_o = ~dq_o; // inverted: never a stale copy
        dm_o = ~dm_o;
        busy = 1'b0;
    endtask
endmodule // lbrws_ctrl_model
`default_nettype wire

// [verification/lbrws_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****
// burst sequencer bench
// ****
module lbrws_top_tb
    import lbrws_pkg::*;
;
    // design inputs
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic dqs_clk_i;
    logic [2:0] cmd_i = CMD_NOP;
    logic [BANK_W-1:0] ba_i = '0;
    logic [COL_W-1:0] col_i = '0; // bursts start on column zero
    logic a10_i = 1'b0;
    logic [1:0] bl_sel_i = BL_SEL_8;
    logic cl3_i = 1'b0;
    logic [DQ_W-1:0] dq_i;
    logic [LANES-1:0] dm_i;
    // design outputs
    logic [PAIR_W-1:0] rd_pair_o;
    logic rd_valid_o, dq_oe_n_o, dqs_oe_n_o, pre_start_o, rd_active_o, wr_active_o;
    logic [BANK_W-1:0] pre_bank_o;
    logic [NBANK-1:0] bank_open_o;
    // expected array and observed events
    logic [PAIR_W-1:0] mem [256];
    logic [PAIR_W-1:0] rdq [$];
    logic [BANK_W-1:0] preq [$];
    int rdc [$];
    int prc [$];
    int cyc = 0;
    int t0;
    int failures = 0;
    int checks_done = 0;
    lbrws_top i_lbrws_top (
        .clk_i(clk_i), .rst_i(rst_i), .dqs_clk_i(dqs_clk_i), .cmd_i(cmd_i), .ba_i(ba_i),
        .col_i(col_i), .a10_i(a10_i), .bl_sel_i(bl_sel_i), .cl3_i(cl3_i), .dq_i(dq_i),
        .dm_i(dm_i), .rd_pair_o(rd_pair_o), .rd_valid_o(rd_valid_o), .dq_oe_n_o(dq_oe_n_o),
        .dqs_oe_n_o(dqs_oe_n_o), .pre_start_o(pre_start_o), .pre_bank_o(pre_bank_o),
        .bank_open_o(bank_open_o), .rd_active_o(rd_active_o), .wr_active_o(wr_active_o)
    );
    lbrws_ctrl_model i_lbrws_ctrl_model (.rst_i(rst_i), .dqs_clk_o(dqs_clk_i), .dq_o(dq_i), .dm_o(dm_i));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    // cycle stamps; outputs sampled at the falling edge
    always @(posedge clk_i) cyc <= cyc + 1;
    always @(negedge clk_i) begin
        if (rd_valid_o === 1'b1) begin
            rdq.push_back(rd_pair_o);
            rdc.push_back(cyc);
        end
        if (pre_start_o === 1'b1) begin
            preq.push_back(pre_bank_o);
            prc.push_back(cyc);
        end
    end
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // command held for one clock; callers add nop
    task automatic issue(input logic [2:0] c, input logic [1:0] b, input logic a);
        cmd_i = c;
        ba_i = b;
        a10_i = a;
        @(negedge clk_i);
    endtask
    task automatic nop(input int n);
        repeat (n) begin
            cmd_i = CMD_NOP;
            @(negedge clk_i);
        end
    endtask
    task automatic wr(input logic [1:0] b, input logic ap, input int n, input logic [63:0] d0, input logic [7:0] m);
        logic [63:0] d;
        preq.delete();
        issue(CMD_WRITE, b, ap);
        cmd_i = CMD_NOP;
        #17; // first strobe rise one clock after the command
        for (int k = 0; k < n; k++) begin
            d = d0 + 64'(k);
            i_lbrws_ctrl_model.send_pair(d, m);
            for (int j = 0; j < 8; j++) begin
                if (!m[j]) mem[{b, 6'(k)}][8*j +: 8] = d[8*j +: 8];
            end
            #150; // the capture needs pairs four clocks apart
        end
        @(negedge clk_i);
        nop(6); // write recovery and write-to-read before the next command
        check(wr_active_o, 1'b0);
        if (ap) check(preq.size(), 1);
    endtask
    task automatic rd(input logic [1:0] b, input logic ap, input logic [2:0] sc, input int at, input int n, input int w);
        rdq.delete();
        rdc.delete();
        preq.delete();
        prc.delete();
        issue(CMD_READ, b, ap);
        t0 = cyc;
        if (at > 0) begin
            nop(at - 1);
            issue(sc, b, 1'b0);
        end
        nop(12);
        check(rdq.size(), n);
        // stamps are taken at the falling edge before the sampling edge, so CL-1
        check(rdc[0], t0 + (cl3_i ? 2 : 1));
        check(rd_active_o, 1'b0);
        check(rdc[n-1] - rdc[0], n - 1);
        for (int k = 0; k < n; k++) begin
            check(rdq[k], mem[{b, 6'(k % w)}]);
        end
        if (!ap && sc != CMD_PRE) check(preq.size(), 0);
    endtask
    task automatic finish_test();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog well beyond the whole sequence
    initial begin
        #200000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        check({rd_valid_o, dq_oe_n_o, dqs_oe_n_o, pre_start_o, bank_open_o}, 8'h60);
        issue(CMD_ACT, 2'h1, 1'b0);
        issue(CMD_ACT, 2'h2, 1'b0);
        nop(1);
        check(bank_open_o, 4'h6);
        wr(2'h1, 1'b0, 4, 64'h1111_2222_3333_4444, 8'h00);
        bl_sel_i = BL_SEL_4;
        wr(2'h1, 1'b0, 2, 64'hA5A5_0F0F_5A5A_F0F0, 8'h3C);
        i_lbrws_ctrl_model.send_pair(64'hDEAD_BEEF_DEAD_BEEF, 8'h00); // unarmed pair
        nop(6);
        bl_sel_i = BL_SEL_8;
        rd(2'h1, 1'b0, CMD_NOP, 0, 4, 4);
        rd(2'h1, 1'b0, CMD_BST, 1, 1, 1); // one pair wanted: terminate one clock later
        check(bank_open_o[1], 1'b1);
        cl3_i = 1'b1;
        rd(2'h1, 1'b0, CMD_NOP, 0, 4, 4);
        cl3_i = 1'b0;
        bl_sel_i = BL_SEL_4;
        rd(2'h1, 1'b0, CMD_READ, 2, 4, 2);
        wr(2'h2, 1'b1, 2, 64'h0102_0304_0506_0708, 8'h00); // read ended before write
        issue(CMD_ACT, 2'h2, 1'b0);
        nop(2);
        rd(2'h2, 1'b0, CMD_NOP, 0, 2, 2);
        bl_sel_i = BL_SEL_8;
        rd(2'h1, 1'b0, CMD_PRE, 2, 2, 2);
        check(prc[0], rdc[1]);
        check(bank_open_o[1], 1'b0);
        issue(CMD_ACT, 2'h1, 1'b0); // row precharge time long past
        nop(2);
        rd(2'h1, 1'b1, CMD_NOP, 0, 4, 4);
        check(prc[0], t0 + 3); // BL/2 edges, stamped one falling edge early
        check(preq[0], 2'h1);
        finish_test();
    end
endmodule // lbrws_top_tb
`default_nettype wire
